// File: logic/tmr_core.sv
/*
  Timer core: counter, comparator counter and single-output PWM modes.
  Assumes timer_in and comparator_out may change at any time and are synchronised
  here; configuration and byte writes come synchronous to clk from software logic.
*/
`timescale 1ns/1ps
module tmr_core
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      arst_n,
  // Configuration and byte writes
  input  tmr_cfg_t       cfg,
  input  tmr_wr_t        wr,
  // Event sources
  input  wire logic      timer_in,
  input  wire logic      comparator_out,
  // Results
  output tmr_regs_t      regs_ff,
  output logic           timer_out_ff,
  output logic           irq_ff
);

  logic                 tin_s1_ff;
  logic                 tin_s2_ff;
  logic                 tin_s3_ff;
  logic                 cmp_s1_ff;
  logic                 cmp_s2_ff;
  logic                 cmp_s3_ff;
  logic [TMR_PRE_W-1:0] pre_ff;
  logic [TMR_PRE_W-1:0] nxt_pre;
  tmr_regs_t            nxt_regs;
  logic                 nxt_timer_out;
  logic                 nxt_irq;
  logic                 tick;
  logic [15:0]          count_inc;

  // Edge detector shared by the pin and the comparator path.
  function automatic logic edge_hit(input logic prev, input logic cur, input logic falling);
    edge_hit = falling ? (prev & ~cur) : (~prev & cur);
  endfunction

  // Terminal value of the prescaler for a divide by two to the power of psc.
  function automatic logic [TMR_PRE_W-1:0] pre_last(input logic [TMR_PSC_W-1:0] psc);
    logic [TMR_PRE_W:0] one_hot;
    one_hot  = {{TMR_PRE_W{1'b0}}, 1'b1} << psc;
    pre_last = one_hot[TMR_PRE_W-1:0] - {{(TMR_PRE_W-1){1'b0}}, 1'b1};
  endfunction

  // Only the second and third stages feed the edge detectors, never the first.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tin_s1_ff <= 1'b0;
      tin_s2_ff <= 1'b0;
      tin_s3_ff <= 1'b0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      cmp_s3_ff <= 1'b0;
    end else begin
      tin_s1_ff <= timer_in;
      tin_s2_ff <= tin_s1_ff;
      tin_s3_ff <= tin_s2_ff;
      cmp_s1_ff <= comparator_out;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_s3_ff <= cmp_s2_ff;
    end
  end

  always_comb begin
    nxt_regs      = regs_ff;
    nxt_timer_out = timer_out_ff;
    nxt_irq       = 1'b0;
    nxt_pre       = TMR_PRE_RST;
    tick          = 1'b0;
    count_inc     = regs_ff.count + 16'h0001;
    case (cfg.mode)
      TMR_MODE_COUNTER: begin
        tick = edge_hit(tin_s3_ff, tin_s2_ff, cfg.output_polarity_select);
      end
      TMR_MODE_CMP_COUNTER: begin
        tick = edge_hit(cmp_s3_ff, cmp_s2_ff, cfg.output_polarity_select);
      end
      TMR_MODE_PWM: begin
        tick    = (pre_ff == pre_last(cfg.prescale));
        nxt_pre = tick ? TMR_PRE_RST : pre_ff + {{(TMR_PRE_W-1){1'b0}}, 1'b1};
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    if (!cfg.enable) begin
      nxt_pre       = TMR_PRE_RST;
      nxt_timer_out = cfg.output_polarity_select;
    end else if (tick) begin
      if (regs_ff.count == regs_ff.reload) begin
        nxt_regs.count = TMR_RESTART;
        nxt_irq        = 1'b1;
        if (cfg.mode == TMR_MODE_PWM) begin
          nxt_timer_out = cfg.output_polarity_select;
        end else begin
          nxt_timer_out = ~timer_out_ff;
        end
      end else begin
        nxt_regs.count = count_inc;
        if ((cfg.mode == TMR_MODE_PWM) && (count_inc == regs_ff.pwm)) begin
          nxt_timer_out = ~cfg.output_polarity_select;
        end
      end
    end
    // A software byte write wins over counting for the byte it writes in the same cycle; the other count byte still takes the counted value.
    if (wr.valid) begin
      case (wr.sel)
        TMR_WR_COUNT_HI: begin
          nxt_regs.count[TMR_HI_MSB:TMR_HI_LSB] = wr.data;
        end
        TMR_WR_COUNT_LO: begin
          nxt_regs.count[TMR_LO_MSB:TMR_LO_LSB] = wr.data;
        end
        TMR_WR_RELOAD_HI: begin
          nxt_regs.reload[TMR_HI_MSB:TMR_HI_LSB] = wr.data;
        end
        TMR_WR_RELOAD_LO: begin
          nxt_regs.reload[TMR_LO_MSB:TMR_LO_LSB] = wr.data;
        end
        TMR_WR_PWM_HI: begin
          nxt_regs.pwm[TMR_HI_MSB:TMR_HI_LSB] = wr.data;
        end
        TMR_WR_PWM_LO: begin
          nxt_regs.pwm[TMR_LO_MSB:TMR_LO_LSB] = wr.data;
        end
        default: begin
          nxt_regs = nxt_regs;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regs_ff.count  <= TMR_COUNT_RST;
      regs_ff.reload <= TMR_RELOAD_RST;
      regs_ff.pwm    <= TMR_PWM_RST;
      pre_ff         <= TMR_PRE_RST;
      timer_out_ff   <= 1'b0;
      irq_ff         <= 1'b0;
    end else begin
      regs_ff        <= nxt_regs;
      pre_ff         <= nxt_pre;
      timer_out_ff   <= nxt_timer_out;
      irq_ff         <= nxt_irq;
    end
  end

endmodule

// File: inc/tmr_pkg.sv
/*
  Constants, types and carriers for the 16-bit reloadable timer with counter,
  comparator counter and single-output PWM modes.
  Assumes the includer compiles this package before any module that imports it.
*/
// Contract
// - Sixteen-bit counter with sixteen-bit reload, both loaded through high and low bytes.
// - Counter mode toggles the timer output at every reload.
// - Counter mode counts rising or falling timer input edges per polarity select.
// - Edge select also fixes the starting output level, routed to a pin or not.
// - Counter mode start count serves first pass only; reloads restart at 0001H.
// - Input edges since start equal current count minus starting count.
// - Comparator counter mode counts comparator output edges instead of the pin.
// - Polarity select picks rising or falling comparator edges.
// - Comparator counter mode bypasses the prescaler; each edge counts directly.
// - PWM mode counts prescaled clocks up and toggles output at the match value.
// - PWM mode at reload raises interrupt, sets count to 0001H, keeps counting.
// - PWM with polarity one starts high, low at match, high at restart.
// - PWM with polarity zero starts low, high at match, low at restart.
// - PWM start count serves first period only; later periods begin at 0001H.
package tmr_pkg;

  localparam int          TMR_PRE_W      = 7;
  localparam int          TMR_PSC_W      = 3;
  localparam logic [15:0] TMR_COUNT_RST  = 16'h0001;
  localparam logic [15:0] TMR_RESTART    = 16'h0001;
  localparam logic [15:0] TMR_RELOAD_RST = 16'hFFFF;
  localparam logic [15:0] TMR_PWM_RST    = 16'h0000;
  localparam logic [6:0]  TMR_PRE_RST    = 7'h00;
  localparam int          TMR_HI_MSB     = 15;
  localparam int          TMR_HI_LSB     = 8;
  localparam int          TMR_LO_MSB     = 7;
  localparam int          TMR_LO_LSB     = 0;

  typedef enum logic [2:0] {
    TMR_MODE_COUNTER     = 3'h1,
    TMR_MODE_CMP_COUNTER = 3'h2,
    TMR_MODE_PWM         = 3'h4
  } tmr_mode_t;

  typedef enum logic [5:0] {
    TMR_WR_COUNT_HI  = 6'h01,
    TMR_WR_COUNT_LO  = 6'h02,
    TMR_WR_RELOAD_HI = 6'h04,
    TMR_WR_RELOAD_LO = 6'h08,
    TMR_WR_PWM_HI    = 6'h10,
    TMR_WR_PWM_LO    = 6'h20
  } tmr_wsel_t;

  typedef struct packed {
    logic                 enable;
    tmr_mode_t            mode;
    logic                 output_polarity_select;
    logic [TMR_PSC_W-1:0] prescale;
  } tmr_cfg_t;

  typedef struct packed {
    logic      valid;
    tmr_wsel_t sel;
    logic [7:0] data;
  } tmr_wr_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] pwm;
  } tmr_regs_t;

endpackage

// File: verif/tmr_checker.sv
/* Port checker for tmr_core. Assumes a bind to every tmr_core instance. */
`timescale 1ns/1ps
module tmr_checker
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input tmr_cfg_t  cfg,
  input tmr_wr_t   wr,
  input wire logic timer_in,
  input wire logic comparator_out,
  input tmr_regs_t regs_ff,
  input logic      timer_out_ff,
  input logic      irq_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_pin;
    $rose(timer_in) && cfg.enable && cfg.mode == TMR_MODE_COUNTER && !cfg.output_polarity_select;
  endsequence
  sequence s_tick;
    ##[1:4] regs_ff.count != $past(regs_ff.count);
  endsequence
  AST_WR: assert property (wr.valid && wr.sel == TMR_WR_COUNT_LO |=> regs_ff.count[7:0] == $past(wr.data))
    else $error("byte write lost");
  AST_OFF: assert property (!cfg.enable |=> timer_out_ff == $past(cfg.output_polarity_select))
    else $error("idle level wrong");
  AST_IRQ: assert property (irq_ff && !$past(wr.valid) |-> regs_ff.count == TMR_RESTART)
    else $error("restart value wrong");
  AST_TGL: assert property (irq_ff && $past(cfg.mode) != TMR_MODE_PWM |-> timer_out_ff != $past(timer_out_ff))
    else $error("no toggle at reload");
  AST_PWM: assert property (irq_ff && $past(cfg.mode) == TMR_MODE_PWM |-> timer_out_ff == $past(cfg.output_polarity_select))
    else $error("pwm restart level wrong");
  AST_STEP: assert property ($past(cfg.enable) && !$past(wr.valid) && !irq_ff && $changed(regs_ff.count)
    |-> regs_ff.count == $past(regs_ff.count) + 16'h0001)
    else $error("count step wrong");
  AST_MATCH: assert property ($past(cfg.mode) == TMR_MODE_PWM && $past(cfg.enable) && !$past(wr.valid) && !irq_ff
    && regs_ff.count == regs_ff.pwm && $changed(regs_ff.count) |-> timer_out_ff != $past(cfg.output_polarity_select))
    else $error("no toggle at match");
  AST_EDGE: assert property (s_pin |-> s_tick)
    else $error("edge not counted");
endmodule
bind tmr_core tmr_checker u_chk (.clk, .arst_n, .cfg, .wr, .timer_in, .comparator_out, .regs_ff, .timer_out_ff, .irq_ff);

// File: verif/tmr_src.sv
/* Edge source for the timer and comparator pins. Assumes clk is the timer clock. */
`timescale 1ns/1ps
module tmr_src (
  input  wire logic clk,
  output logic      timer_in,
  output logic      comparator_out
);
  initial begin
    timer_in = 1'b0;
    comparator_out = 1'b0;
  end
  // Each level stands two clocks so that the synchroniser sees every edge.
  task automatic flip(input logic cmp, input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      #2;
      if (cmp) comparator_out = !comparator_out;
      else timer_in = !timer_in;
    end
  endtask
endmodule

// File: verif/timer_counter_pwm_modes_tb_top.sv
/* Top bench for tmr_core. Assumes tmr_src drives the pins and tmr_checker is bound. */
`timescale 1ns/1ps
module timer_counter_pwm_modes_tb_top;
  import tmr_pkg::*;
  logic      clk;
  logic      arst_n;
  tmr_cfg_t  cfg;
  tmr_wr_t   wr;
  tmr_regs_t regs;
  logic      t_in;
  logic      c_out;
  logic      t_out;
  logic      irq;
  int        miscompares;
  int        tests_run;
  logic [15:0] c;
  tmr_core DUT (.clk(clk), .arst_n(arst_n), .cfg(cfg), .wr(wr), .timer_in(t_in), .comparator_out(c_out),
    .regs_ff(regs), .timer_out_ff(t_out), .irq_ff(irq));
  tmr_src SRC (.clk(clk), .timer_in(t_in), .comparator_out(c_out));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask
  // Writes the high byte, then the low byte in the next cycle; valid is left high.
  task automatic wr16(input tmr_wsel_t hi, input logic [15:0] v);
    wr = '{1'b1, hi, v[15:8]};
    @(posedge clk);
    #2;
    wr = '{1'b1, tmr_wsel_t'(hi << 1), v[7:0]};
    @(posedge clk);
    #2;
  endtask
  task automatic start(input tmr_mode_t m, input logic p, input logic [2:0] ps, input logic [15:0] s, r, w);
    cfg = '{1'b0, m, p, ps};
    wr16(TMR_WR_COUNT_HI, s);
    wr16(TMR_WR_PWM_HI, w);
    wr16(TMR_WR_RELOAD_HI, r);
    wr.valid = 1'b0;
    cfg.enable = 1'b1;
  endtask
  task automatic go(input logic cmp, input int n, input logic [15:0] exp);
    SRC.flip(cmp, n);
    repeat (4) @(posedge clk);
    #2;
    cmp16(regs.count, exp);
  endtask
  task automatic print_verdict();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
  initial begin
    cfg = '0;
    wr = '0;
    arst_n = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    #2;
    arst_n = 1'b1;
    cmp16(regs.count, TMR_COUNT_RST);
    cmp16(regs.reload, TMR_RELOAD_RST);
    cmp16(regs.pwm, TMR_PWM_RST);
    start(TMR_MODE_COUNTER, 1'b0, 3'h0, 16'h0001, 16'h0003, 16'h0000);
    cmp1(t_out, 1'b0);
    go(1'b0, 2, 16'h0002);
    go(1'b0, 2, 16'h0003);
    go(1'b0, 2, 16'h0001);
    cmp1(t_out, 1'b1);
    go(1'b0, 4, 16'h0003);
    start(TMR_MODE_CMP_COUNTER, 1'b1, 3'h7, 16'h0001, 16'h0009, 16'h0000);
    go(1'b1, 4, 16'h0003);
    go(1'b0, 4, 16'h0003);
    for (int p = 0; p < 2; p++) begin
      start(TMR_MODE_PWM, p[0], 3'h0, 16'h0002, 16'h0005, 16'h0003);
      c = 16'h0002;
      repeat (12) begin
        @(posedge clk);
        #2;
        c = (c == 16'h0005) ? TMR_RESTART : c + 16'h0001;
        cmp16(regs.count, c);
        cmp1(irq, c == TMR_RESTART);
        cmp1(t_out, (c >= 16'h0003) ? !p[0] : p[0]);
      end
    end
    start(TMR_MODE_PWM, 1'b0, 3'h1, 16'h0001, 16'hFFFF, 16'h0000);
    repeat (8) @(posedge clk);
    #2;
    cmp16(regs.count, 16'h0005);
    print_verdict();
  end
endmodule
